/* File: clk_pin_board.sv */
// Board load on the clock pin: pull-up plus a rising edge counter.
// Assumes the pin is sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module clk_pin_board
(
  input wire logic clk_i,
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic level_o,
  output logic [15:0] rise_cnt_o
);
  logic last_r = 1'b1;
  logic [15:0] cnt_r = 16'h0000;
  // Released pin floats up to the pull-up
  assign level_o = pin_oe_i ? pin_i : 1'b1;
  assign rise_cnt_o = cnt_r;
  always_ff @(posedge clk_i)
  begin
    last_r <= level_o;
    cnt_r <= cnt_r + {15'h0000, level_o & ~last_r};
  end
endmodule
`default_nettype wire

/* File: clkout_chk.sv */
// Port checks for the clock output and direct speed switch block.
// Assumes ce_i high and the settle base of the bound instance.
`timescale 1ns/1ps
`default_nettype none
module clkout_chk
#(
  parameter int SETTLE_BASE_CYCLES = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic pulse_pending_o,
  input wire logic direct_irq_o,
  input wire logic [3:0] mode_o,
  input wire logic clk_pin_o,
  input wire logic clk_pin_oe_o,
  input wire logic [7:0] port_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_enter_direct;
    $past(mode_o) == 4'h2 && mode_o == 4'h7;
  endsequence
  sequence s_hold_direct;
    (mode_o == 4'h7) [*4];
  endsequence
  property p_settle;
    s_enter_direct |-> s_hold_direct ##[1:600] mode_o == 4'h0;
  endproperty
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_irq;
    $fell(mode_o == 4'h7) && mode_o != 4'h8 |-> direct_irq_o;
  endproperty
  property p_hw_hiz;
    (mode_o == 4'h8) [*2] |-> !clk_pin_oe_o;
  endproperty
  property p_fixed_high;
    (mode_o inside {4'h5, 4'h6, 4'h7}) [*2] |-> clk_pin_o;
  endproperty
  property p_pend_hold;
    mode_o == 4'h2 && pulse_pending_o |=> pulse_pending_o || mode_o != 4'h2;
  endproperty
  property p_port_keep;
    (mode_o == 4'h5) [*2] |-> $stable(port_out_o);
  endproperty
  a_settle: assert property (p_settle) else $error("direct switch too short");
  a_ack: assert property (p_ack) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_irq: assert property (p_irq) else $error("no direct irq");
  a_hw_hiz: assert property (p_hw_hiz) else $error("pin driven in hw standby");
  a_fixed_high: assert property (p_fixed_high) else $error("pin not high");
  a_pend_hold: assert property (p_pend_hold) else $error("pending withdrawn");
  a_port_keep: assert property (p_port_keep) else $error("port moved in standby");
endmodule
bind clock_out_and_direct_speed_switch clkout_chk #(.SETTLE_BASE_CYCLES(SETTLE_BASE_CYCLES)) chk
  (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pulse_pending_o(pulse_pending_o), .direct_irq_o(direct_irq_o),
  .mode_o(mode_o), .clk_pin_o(clk_pin_o), .clk_pin_oe_o(clk_pin_oe_o),
  .port_out_o(port_out_o));
`default_nettype wire

/* File: clkout_pkg.sv */
// Constants for the clock output and direct speed switch block.
// Assumes a 32-bit classic Wishbone register bus and a 200 MHz system clock.
`default_nettype none

package clkout_pkg;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] PORT_OFS = 4'h8;
  localparam logic [3:0] PEND_OFS = 4'hC;

  // Control register fields
  localparam int STANDBY_SELECT_BIT = 0;
  localparam int LOW_SPEED_ON_BIT = 1;
  localparam int DIRECT_TRANSITION_ON_BIT = 2;
  localparam int PRESCALER_SELECT_SUB_BIT = 3;
  localparam int SETTLE_LSB = 4;
  localparam int SYS_CLOCK_OUT_STOP_BIT = 7;
  localparam int CLK_PIN_DIR_BIT = 8;
  localparam int DIVIDER_LSB = 9;
  localparam int CTRL_WIDTH = 12;
  localparam logic [11:0] CTRL_RESET = 12'h000;

  // Port output register
  localparam int PORT_WIDTH = 8;
  localparam logic [7:0] PORT_RESET = 8'h00;

  // Settling time: base count, doubled per settle_time_select step
  localparam int SETTLE_BASE_DEFAULT = 1024;
  localparam int SETTLE_CNT_WIDTH = 18;

  typedef enum logic [3:0] {
    MODE_HIGH,
    MODE_MEDIUM,
    MODE_SUBACTIVE,
    MODE_SLEEP,
    MODE_SUBSLEEP,
    MODE_SW_STANDBY,
    MODE_WATCH,
    MODE_DIRECT,
    MODE_HW_STANDBY
  } mode_t;

endpackage

`default_nettype wire

/* File: clock_out_and_direct_speed_switch.sv */
// Power-mode sequencer and system clock output pin control.
// Assumes a classic Wishbone master on clk_i; hw_standby_n_i and sub_clk_i
// come from pins and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module clock_out_and_direct_speed_switch
  import clkout_pkg::*;
#(
  parameter int SETTLE_BASE_CYCLES = SETTLE_BASE_DEFAULT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // CPU events
  input wire logic sleep_exec_i,
  input wire logic wake_irq_i,
  input wire logic pulse_req_i,
  output logic pulse_pending_o,
  output logic direct_irq_o,
  output logic [3:0] mode_o,
  // Pins
  input wire logic hw_standby_n_i,
  input wire logic sub_clk_i,
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  output logic [7:0] port_out_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] stby_sync_r;
  logic [1:0] sub_sync_r;
  logic [1:0] pin_sync_r;
  logic hw_stby;
  logic sub_clk;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stby_sync_r <= 2'h3;
      sub_sync_r <= 2'h0;
      pin_sync_r <= 2'h3;
    end
    else if (ce_i)
    begin
      stby_sync_r <= {stby_sync_r[0], hw_standby_n_i};
      sub_sync_r <= {sub_sync_r[0], sub_clk_i};
      pin_sync_r <= {pin_sync_r[0], clk_pin_i};
    end
  end

  assign hw_stby = !stby_sync_r[1];
  assign sub_clk = sub_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [CTRL_WIDTH-1:0] ctrl_r;
  logic [PORT_WIDTH-1:0] port_r;
  logic pending_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic bus_req;
  logic wr_ctrl;
  logic wr_port;
  logic wr_pend;
  logic [31:0] rd_mux;
  mode_t mode_r;
  mode_t mode_nxt;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_ctrl = bus_req && wb_we_i && (wb_adr_i == CTRL_OFS);
  assign wr_port = bus_req && wb_we_i && (wb_adr_i == PORT_OFS) && wb_sel_i[0];
  assign wr_pend = bus_req && wb_we_i && (wb_adr_i == PEND_OFS) && wb_sel_i[0];

  function automatic logic [CTRL_WIDTH-1:0] merge_ctrl(input logic [CTRL_WIDTH-1:0] old,
                                                       input logic [31:0] d,
                                                       input logic [3:0] sel);
    logic [CTRL_WIDTH-1:0] r;
    r = old;
    if (sel[0])
      r[7:0] = d[7:0];
    if (sel[1])
      r[CTRL_WIDTH-1:8] = d[CTRL_WIDTH-1:8];
    merge_ctrl = r;
  endfunction

  // Status: pin level, settle busy, current mode
  logic settle_busy;
  logic settle_done;
  logic [31:0] status_word;
  assign status_word = {26'h0, pin_sync_r[1], settle_busy, mode_r};

  assign rd_mux = (wb_adr_i == CTRL_OFS) ? {20'h0, ctrl_r} :
                  (wb_adr_i == STATUS_OFS) ? status_word :
                  (wb_adr_i == PORT_OFS) ? {24'h0, port_r} :
                  (wb_adr_i == PEND_OFS) ? {31'h0, pending_r} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
      ctrl_r <= CTRL_RESET;
      port_r <= PORT_RESET;
    end
    else if (ce_i)
    begin
      ack_r <= bus_req;
      if (bus_req)
        rdat_r <= rd_mux;
      if (wr_ctrl)
        ctrl_r <= merge_ctrl(ctrl_r, wb_dat_i, wb_sel_i);
      if (wr_port)
        port_r <= wb_dat_i[7:0]; // Never touched by mode changes
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign port_out_o = port_r;

  ////////////////////////////////////////////////////////////////////////
  // Pulse unit pending request

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pending_r <= 1'b0;
    else if (ce_i)
    begin
      if (pulse_req_i)
        pending_r <= 1'b1;
      else if (wr_pend && wb_dat_i[0] && mode_r != MODE_SUBACTIVE)
        pending_r <= 1'b0; // Clear refused in subactive
    end
  end

  assign pulse_pending_o = pending_r;

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencer

  logic standby_select;
  logic low_speed_on;
  logic direct_transition_on;
  logic prescaler_select_sub;
  logic [2:0] divider;
  logic go_watch;
  logic go_subsleep;
  logic go_sub_to_high;
  logic go_high_to_sub;
  mode_t run_mode;
  mode_t direct_target_r;

  assign standby_select = ctrl_r[STANDBY_SELECT_BIT];
  assign low_speed_on = ctrl_r[LOW_SPEED_ON_BIT];
  assign direct_transition_on = ctrl_r[DIRECT_TRANSITION_ON_BIT];
  assign prescaler_select_sub = ctrl_r[PRESCALER_SELECT_SUB_BIT];
  assign divider = ctrl_r[DIVIDER_LSB+2:DIVIDER_LSB];
  assign run_mode = (divider == 3'h0) ? MODE_HIGH : MODE_MEDIUM;
  assign go_watch = standby_select && !direct_transition_on && prescaler_select_sub;
  assign go_subsleep = !standby_select && low_speed_on && prescaler_select_sub;
  assign go_sub_to_high = standby_select && !low_speed_on && direct_transition_on &&
                          prescaler_select_sub;
  assign go_high_to_sub = standby_select && low_speed_on && direct_transition_on &&
                          prescaler_select_sub;

  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_HIGH, MODE_MEDIUM:
        if (sleep_exec_i)
        begin
          if (!standby_select)
            mode_nxt = MODE_SLEEP;
          else if (go_high_to_sub)
            mode_nxt = MODE_DIRECT;
          else if (go_watch)
            mode_nxt = MODE_WATCH;
          else
            mode_nxt = MODE_SW_STANDBY;
        end
      MODE_SUBACTIVE:
        if (sleep_exec_i)
        begin
          if (go_sub_to_high)
            mode_nxt = MODE_DIRECT;
          else if (go_watch)
            mode_nxt = MODE_WATCH;
          else if (go_subsleep)
            mode_nxt = MODE_SUBSLEEP;
          else
            mode_nxt = MODE_SUBACTIVE;
        end
      MODE_SLEEP, MODE_SW_STANDBY:
        if (wake_irq_i)
          mode_nxt = run_mode;
      MODE_SUBSLEEP:
        if (wake_irq_i)
          mode_nxt = MODE_SUBACTIVE;
      MODE_WATCH:
        if (wake_irq_i)
          mode_nxt = low_speed_on ? MODE_SUBACTIVE : run_mode;
      MODE_DIRECT:
        if (direct_target_r == MODE_SUBACTIVE || settle_done)
          mode_nxt = direct_target_r; // Waits out settling only on the switch to high speed
      MODE_HW_STANDBY:
        mode_nxt = MODE_HIGH;
      default:
        mode_nxt = MODE_HIGH;
    endcase
    if (hw_stby)
      mode_nxt = MODE_HW_STANDBY;
  end

  logic settle_start;
  logic direct_irq_r;
  assign settle_start = (mode_r == MODE_SUBACTIVE) && sleep_exec_i && go_sub_to_high && !hw_stby;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= MODE_HIGH;
      direct_target_r <= MODE_HIGH;
      direct_irq_r <= 1'b0;
    end
    else if (ce_i)
    begin
      mode_r <= mode_nxt;
      if (mode_r != MODE_DIRECT)
        direct_target_r <= (mode_r == MODE_SUBACTIVE) ? MODE_HIGH : MODE_SUBACTIVE;
      direct_irq_r <= (mode_r == MODE_DIRECT) && (mode_nxt != MODE_DIRECT) && !hw_stby;
    end
  end

  assign direct_irq_o = direct_irq_r;
  assign mode_o = mode_r;

  settle_timer #(
    .SETTLE_BASE_CYCLES(SETTLE_BASE_CYCLES)
  ) u_settle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(settle_start),
    .sel_i(ctrl_r[SETTLE_LSB+2:SETTLE_LSB]),
    .busy_o(settle_busy),
    .done_o(settle_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock output pin

  logic phi_r;
  logic stop_eff_r;
  logic pin_r;
  logic oe_r;
  logic pin_nxt;
  logic oe_nxt;
  logic show_phi;
  logic show_sub;

  // Stop takes effect only with phi_r high, ending the system clock cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phi_r <= 1'b1;
      stop_eff_r <= 1'b0;
    end
    else if (ce_i)
    begin
      phi_r <= !phi_r;
      if (phi_r)
        stop_eff_r <= ctrl_r[SYS_CLOCK_OUT_STOP_BIT];
    end
  end

  assign show_phi = (mode_r == MODE_HIGH) || (mode_r == MODE_MEDIUM) ||
                    (mode_r == MODE_SLEEP) || (mode_r == MODE_SUBSLEEP);
  assign show_sub = (mode_r == MODE_SUBACTIVE);
  assign oe_nxt = ctrl_r[CLK_PIN_DIR_BIT] && (mode_r != MODE_HW_STANDBY);
  assign pin_nxt = stop_eff_r ? 1'b1 :
                   show_phi ? !phi_r :
                   show_sub ? sub_clk : 1'b1;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_r <= 1'b1;
      oe_r <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign clk_pin_o = pin_r;
  assign clk_pin_oe_o = oe_r;

endmodule

`default_nettype wire

/* File: clock_out_and_direct_speed_switch_test.sv */
// Self-checking bench for the clock output and speed switch block.
// Assumes the board model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module clock_out_and_direct_speed_switch_test;
  import clkout_pkg::*;
  typedef struct {logic [11:0] ctrl; logic oe; logic tog;} row_t;
  row_t rows [4] = '{'{12'h000, 1'b0, 1'b0}, '{12'h080, 1'b0, 1'b0},
    '{12'h100, 1'b1, 1'b1}, '{12'h180, 1'b1, 1'b0}};
  logic clk_i, rst_i, cyc, stb, we, ack, slp, wake, preq, pend, dirq, hwn, sub, pin, oe, lvl;
  logic [3:0] adr, mode, sel;
  logic [31:0] dat, rdat, rd;
  logic [7:0] port;
  logic [15:0] rise, base;
  int miscompares, checks_done, k, irqs, t0;
  clock_out_and_direct_speed_switch #(.SETTLE_BASE_CYCLES(4)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sleep_exec_i(slp), .wake_irq_i(wake), .pulse_req_i(preq), .pulse_pending_o(pend),
    .direct_irq_o(dirq), .mode_o(mode), .hw_standby_n_i(hwn), .sub_clk_i(sub),
    .clk_pin_i(lvl), .clk_pin_o(pin), .clk_pin_oe_o(oe), .port_out_o(port));
  clk_pin_board board (.clk_i(clk_i), .pin_i(pin), .pin_oe_i(oe), .level_o(lvl),
    .rise_cnt_o(rise));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // The CPU model is the only master writing control state
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k == 20)
    begin
      miscompares++;
      results();
    end
  endtask
  task automatic sleep_now;
    @(posedge clk_i);
    slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
  endtask
  task automatic wake_now;
    @(posedge clk_i);
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
  endtask
  task automatic wait_mode(input logic [3:0] m);
    k = 0;
    while (mode !== m && k < 2000)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k == 2000)
    begin
      miscompares++;
      results();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    sub <= 1'(($time / 40) % 2);
    if (dirq === 1'b1)
      irqs <= irqs + 1;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    results();
  end
  initial
  begin
    {rst_i, cyc, stb, we, slp, wake, preq, hwn} = 8'h81;
    {adr, sel, dat} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({mode, oe, pin, port}, {4'h0, 2'h1, 8'h00}, "reset outputs");
    wb(1'b0, 4'h2, 0);
    chk(rd, 0, "unmapped read");
    $display("reset test done");
    foreach (rows[i])
    begin
      wb(1'b1, CTRL_OFS, {20'h0, rows[i].ctrl});
      repeat (6) @(posedge clk_i);
      base = rise;
      repeat (8) @(posedge clk_i);
      chk(oe, rows[i].oe, "pin enable");
      chk(rise != base, rows[i].tog, "pin toggling");
    end
    $display("pin table test done");
    wb(1'b1, CTRL_OFS, 32'h10F);
    sleep_now();
    wait_mode(4'h2);
    base = rise;
    repeat (40) @(posedge clk_i);
    chk(rise != base, 1, "subclock on pin");
    @(posedge clk_i);
    preq <= 1'b1;
    @(posedge clk_i);
    preq <= 1'b0;
    wb(1'b1, PEND_OFS, 1);
    wb(1'b0, PEND_OFS, 0);
    chk(rd, 1, "pending kept");
    wb(1'b1, CTRL_OFS, 32'h10C);
    sleep_now();
    repeat (10) @(posedge clk_i);
    chk(mode, 4'h2, "undefined combo");
    wb(1'b1, CTRL_OFS, 32'h12D);
    t0 = irqs;
    sleep_now();
    wait_mode(4'h0);
    chk(k >= 16 && k <= 22, 1, "settle length");
    @(posedge clk_i);
    chk(irqs - t0, 1, "direct irq");
    wb(1'b1, PEND_OFS, 1);
    wb(1'b0, PEND_OFS, 0);
    chk(rd, 0, "pending cleared");
    $display("direct switch test done");
    wb(1'b1, PORT_OFS, 32'hA5);
    wb(1'b1, CTRL_OFS, 32'h101);
    sleep_now();
    repeat (10) @(posedge clk_i);
    base = rise;
    repeat (8) @(posedge clk_i);
    chk({mode, port, lvl}, {4'h5, 8'hA5, 1'b1}, "standby");
    chk(rise, base, "standby pin still");
    wake_now();
    wait_mode(4'h0);
    wb(1'b1, CTRL_OFS, 32'h109);
    sleep_now();
    wait_mode(4'h6);
    repeat (4) @(posedge clk_i);
    base = rise;
    repeat (8) @(posedge clk_i);
    chk({mode, rise != base}, {4'h6, 1'b0}, "watch pin fixed");
    wb(1'b1, CTRL_OFS, 32'h300);
    wake_now();
    wait_mode(4'h1);
    base = rise;
    repeat (8) @(posedge clk_i);
    chk(rise != base, 1, "medium pin clock");
    sleep_now();
    wait_mode(4'h3);
    base = rise;
    repeat (8) @(posedge clk_i);
    chk(rise != base, 1, "sleep pin clock");
    wb(1'b1, CTRL_OFS, 32'h100);
    wake_now();
    wait_mode(4'h0);
    hwn <= 1'b0;
    wait_mode(4'h8);
    repeat (3) @(posedge clk_i);
    chk(oe, 0, "hw standby pin");
    hwn <= 1'b1;
    wait_mode(4'h0);
    $display("standby test done");
    results();
  end
endmodule
`default_nettype wire

/* File: settle_timer.sv */
// Settling-time counter for the subactive to high-speed direct switch.
// Assumes start is a one-cycle pulse on clk_i; done pulses once at expiry.
`timescale 1ns/1ps
`default_nettype none

module settle_timer
  import clkout_pkg::*;
#(
  parameter int SETTLE_BASE_CYCLES = SETTLE_BASE_DEFAULT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [2:0] sel_i,
  output logic busy_o,
  output logic done_o
);

  logic [SETTLE_CNT_WIDTH-1:0] cnt_r;
  logic [SETTLE_CNT_WIDTH-1:0] cnt_nxt;
  logic busy_r;
  logic done_r;

  function automatic logic [SETTLE_CNT_WIDTH-1:0] settle_count(input logic [2:0] sel);
    logic [SETTLE_CNT_WIDTH-1:0] base;
    base = SETTLE_CNT_WIDTH'(SETTLE_BASE_CYCLES);
    settle_count = base << sel;
  endfunction

  assign cnt_nxt = start_i ? settle_count(sel_i) - 1'b1 : cnt_r - 1'b1;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (ce_i)
    begin
      done_r <= busy_r && !start_i && (cnt_r == '0);
      if (start_i || busy_r)
        cnt_r <= cnt_nxt;
      if (start_i)
        busy_r <= 1'b1;
      else if (cnt_r == '0)
        busy_r <= 1'b0;
    end
  end

  assign busy_o = busy_r;
  assign done_o = done_r;

endmodule

`default_nettype wire
